// ===== logic/auth_frame.sv
`timescale 1ns/1ns
`include "auth_frame_map.svh"

module auth_frame #(
	parameter int unsigned WAKE_READY_CYC = `WAKE_READY_CYC,
	parameter int unsigned TIMEOUT_CYC = `TIMEOUT_CYC,
	parameter int unsigned WATCHDOG_CYC = `WATCHDOG_CYC
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic link_clock,
	input wire logic sda_in,
	input wire logic i2c_mode,
	input wire logic link_event_valid,
	output logic link_event_ready,
	input wire auth_frame_pkg::link_event_t link_event,
	output logic link_rd_valid,
	output auth_frame_pkg::rd_answer_t link_rd_answer,
	output logic exec_valid,
	output auth_frame_pkg::cmd_t exec_cmd,
	input wire logic exec_done,
	input wire auth_frame_pkg::exec_result_t exec_result,
	output logic asleep,
	output logic idling,
	output logic busy,
	output logic volatile_clear,
	output logic digest_discard
);
	import auth_frame_pkg::*;
	localparam int unsigned WAKE_LOW_CYC = `WAKE_LOW_CYC;

	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			c = {c[14:0], 1'b0} ^ ((data[i] ^ c[15]) ? `CRC_POLY : 16'h0000);
		end
		return c;
	endfunction : crc_byte

	function automatic logic flag_is(input logic i2c, input logic [7:0] b,
		input logic [7:0] v_i2c, input logic [7:0] v_sw);
		return i2c ? (b == v_i2c) : (b == v_sw);
	endfunction : flag_is

	// ----------------------------------------
	// Link domain: event hand-off by toggle
	// ----------------------------------------
	logic req_r;
	logic ack_r;
	logic ack_s1_r;
	logic ack_s2_r;
	logic ack_seen_r;
	logic pend_read_r;
	link_event_t hold_r;
	rd_answer_t answer_r;
	rd_answer_t answer_nxt;

	// A new event may only go once the core has acknowledged the last one
	assign link_event_ready = (req_r == ack_s2_r) && (ack_seen_r == ack_s2_r);

	// Hold register stays still until acknowledged, so the core may read it directly
	always_ff @(posedge link_clock or posedge reset) begin
		if (reset) begin
			req_r <= 1'b0;
			hold_r <= '0;
			pend_read_r <= 1'b0;
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			ack_seen_r <= 1'b0;
			link_rd_valid <= 1'b0;
			link_rd_answer <= '0;
		end else begin
			ack_s1_r <= ack_r;
			ack_s2_r <= ack_s1_r;
			ack_seen_r <= ack_s2_r;
			link_rd_valid <= (ack_seen_r != ack_s2_r) && pend_read_r;
			if (ack_seen_r != ack_s2_r) begin
				link_rd_answer <= answer_r; // Stable: core changes it only on a new request
			end
			if (link_event_valid && link_event_ready) begin
				req_r <= ~req_r;
				hold_r <= link_event;
				pend_read_r <= (link_event.kind == ev_read);
			end
		end
	end

	// ----------------------------------------
	// Core domain: synchronisers
	// ----------------------------------------
	logic req_s1_r;
	logic req_s2_r;
	logic sda_s1_r;
	logic sda_s2_r;
	logic mode_s1_r;
	logic mode_s2_r;

	// Two flops on every input from outside this clock except hold_r, which the core reads directly
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			mode_s1_r <= 1'b0;
			mode_s2_r <= 1'b0;
		end else begin
			req_s1_r <= req_r;
			req_s2_r <= req_s1_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			mode_s1_r <= i2c_mode;
			mode_s2_r <= mode_s1_r;
		end
	end

	// ----------------------------------------
	// Core domain: framing and power states
	// ----------------------------------------
	state_t state_r;
	state_t state_nxt;
	logic [31:0] tmr_r;
	logic [31:0] tmr_nxt;
	logic [31:0] wdog_r;
	logic [7:0] idx_r;
	logic [7:0] idx_nxt;
	logic [15:0] crc_r;
	logic [15:0] crc_nxt;
	logic [7:0] crc_lo_r;
	logic [7:0] crc_lo_nxt;
	logic [7:0] code_r;
	logic [7:0] code_nxt;
	logic [2:0] ptr_r;
	logic [2:0] ptr_nxt;
	cmd_t cmd_r;
	cmd_t cmd_nxt;
	logic copy_r;
	logic copy_nxt;
	logic exec_go;

	// Event decode and the fixed four-byte status block
	wire ev_take = (req_s2_r != ack_r);
	wire take_byte = ev_take && (hold_r.kind == ev_byte);
	wire take_read = ev_take && (hold_r.kind == ev_read);
	wire take_edge = ev_take && ((hold_r.kind == ev_start) || (hold_r.kind == ev_stop));
	wire fl_reset = mode_s2_r && (hold_r.data == `FLAG_RESET_I2C);
	wire fl_sleep = flag_is(mode_s2_r, hold_r.data, `FLAG_SLEEP_I2C, `FLAG_SLEEP_SW);
	wire fl_idle = flag_is(mode_s2_r, hold_r.data, `FLAG_IDLE_I2C, `FLAG_IDLE_SW);
	wire fl_cmd = flag_is(mode_s2_r, hold_r.data, `FLAG_CMD_I2C, `FLAG_CMD_SW);
	wire [15:0] blk_crc = crc_byte(crc_byte(`CRC_INIT, `STATUS_COUNT), code_r);
	wire [8:0] pos = {1'b0, idx_r} + 9'h001;
	wire [8:0] cnt = {1'b0, cmd_r.count};
	wire is_awake = (state_r != st_sleep) && (state_r != st_idle);
	wire wdog_fire = is_awake && (wdog_r >= WATCHDOG_CYC - 1);
	wire crc_good = ({hold_r.data, crc_lo_r} == crc_r);
	logic [7:0] out_byte;

	// Block bytes in order: count, code, CRC low, CRC high; past the end reads 0xff
	always_comb begin
		case (ptr_r)
			3'h0: out_byte = `STATUS_COUNT;
			3'h1: out_byte = code_r;
			3'h2: out_byte = blk_crc[7:0];
			3'h3: out_byte = blk_crc[15:8];
			default: out_byte = 8'hff;
		endcase
	end

	// Next-state logic for the whole frame engine
	always_comb begin
		state_nxt = state_r;
		tmr_nxt = tmr_r;
		idx_nxt = idx_r;
		crc_nxt = crc_r;
		crc_lo_nxt = crc_lo_r;
		code_nxt = code_r;
		ptr_nxt = ptr_r;
		cmd_nxt = cmd_r;
		copy_nxt = copy_r;
		exec_go = 1'b0;
		answer_nxt = ev_take ? {1'b0, 8'hff} : answer_r; // Refused unless served
		case (state_r)
			st_sleep, st_idle: begin
				// Link traffic is dropped here; only a long low on the data line wakes
				if (!sda_s2_r) begin
					tmr_nxt = (tmr_r == 32'hffffffff) ? tmr_r : tmr_r + 32'h1;
				end else begin
					tmr_nxt = '0;
					if (tmr_r >= WAKE_LOW_CYC) begin
						state_nxt = st_wake;
					end
				end
			end
			st_wake: begin
				tmr_nxt = tmr_r + 32'h1;
				if (tmr_r >= WAKE_READY_CYC - 1) begin
					state_nxt = st_ready;
					tmr_nxt = '0;
					code_nxt = `CODE_WAKE;
					ptr_nxt = '0;
				end
			end
			st_ready: begin
				if (take_read) begin
					answer_nxt = '{valid: 1'b1, data: out_byte};
					ptr_nxt = (ptr_r == 3'h4) ? ptr_r : ptr_r + 3'h1;
				end else if (take_byte) begin
					if (fl_reset) begin
						ptr_nxt = '0;
					end else if (fl_sleep) begin
						state_nxt = st_sleep;
					end else if (fl_idle) begin
						state_nxt = st_idle;
					end else if (fl_cmd) begin
						state_nxt = st_rx;
						idx_nxt = '0;
						crc_nxt = `CRC_INIT;
						tmr_nxt = '0;
					end
				end
			end
			st_rx: begin
				tmr_nxt = tmr_r + 32'h1;
				if (take_byte) begin
					tmr_nxt = '0;
					idx_nxt = idx_r + 8'h01;
					if (idx_r == 8'h00) begin
						cmd_nxt.count = hold_r.data;
						crc_nxt = crc_byte(crc_r, hold_r.data);
						if (hold_r.data < `CRC_MIN_COUNT) begin
							state_nxt = st_ready; // Too short to carry a CRC
							code_nxt = `CODE_COMM;
							ptr_nxt = '0;
						end
					end else if (pos <= cnt - 9'h002) begin
						crc_nxt = crc_byte(crc_r, hold_r.data);
						case (pos)
							9'h002: cmd_nxt.opcode = hold_r.data;
							9'h003: cmd_nxt.first_parameter = hold_r.data;
							9'h004: cmd_nxt.second_parameter[7:0] = hold_r.data;
							9'h005: cmd_nxt.second_parameter[15:8] = hold_r.data;
							default: ;
						endcase
					end else if (pos == cnt - 9'h001) begin
						crc_lo_nxt = hold_r.data;
					end else begin
						state_nxt = st_ready;
						ptr_nxt = '0;
						if (!crc_good) begin
							code_nxt = `CODE_COMM;
						end else if (cmd_r.count < `CMD_MIN_COUNT) begin
							code_nxt = `CODE_PARSE;
						end else begin
							state_nxt = st_busy;
							exec_go = 1'b1;
						end
					end
				end else if (take_edge && mode_s2_r) begin
					state_nxt = st_ready;
					code_nxt = `CODE_COMM;
					ptr_nxt = '0;
				end else if (!mode_s2_r && (tmr_r >= TIMEOUT_CYC - 1)) begin
					state_nxt = st_sleep;
				end
			end
			st_busy: begin
				// Link events are acknowledged but dropped while executing
				if (exec_done) begin
					state_nxt = st_ready;
					code_nxt = exec_result.code;
					copy_nxt = exec_result.digest_copy;
					ptr_nxt = '0;
				end
			end
			default: state_nxt = st_sleep;
		endcase
		if (wdog_fire) begin
			state_nxt = st_sleep;
		end
		if ((state_nxt == st_sleep) || (state_nxt == st_idle)) begin
			tmr_nxt = (state_r == state_nxt) ? tmr_nxt : '0;
		end
		if ((state_nxt == st_sleep) && (state_r != st_sleep)) begin
			code_nxt = `CODE_OK;
			cmd_nxt = '0;
			copy_nxt = 1'b0;
			ptr_nxt = '0;
			crc_nxt = `CRC_INIT;
		end
		if ((state_nxt == st_idle) && (state_r != st_idle)) begin
			copy_nxt = 1'b0;
		end
	end

	// State and data registers; the watchdog runs only while awake
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_r <= st_sleep;
			tmr_r <= '0;
			wdog_r <= '0;
			idx_r <= '0;
			crc_r <= `CRC_INIT;
			crc_lo_r <= '0;
			code_r <= `CODE_OK;
			ptr_r <= '0;
			cmd_r <= '0;
			copy_r <= 1'b0;
			ack_r <= 1'b0;
			answer_r <= '0;
		end else begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
			wdog_r <= (is_awake && state_nxt != st_sleep) ? wdog_r + 32'h1 : '0;
			idx_r <= idx_nxt;
			crc_r <= crc_nxt;
			crc_lo_r <= crc_lo_nxt;
			code_r <= code_nxt;
			ptr_r <= ptr_nxt;
			cmd_r <= cmd_nxt;
			copy_r <= copy_nxt;
			ack_r <= req_s2_r; // Every event is taken in one cycle
			answer_r <= answer_nxt;
		end
	end

	// Outputs toward the execution engine and the power domain
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			exec_valid <= 1'b0;
			exec_cmd <= '0;
			volatile_clear <= 1'b0;
			digest_discard <= 1'b0;
		end else begin
			exec_valid <= exec_go;
			exec_cmd <= exec_go ? cmd_r : exec_cmd;
			volatile_clear <= (state_nxt == st_sleep) && (state_r != st_sleep);
			digest_discard <= (state_nxt == st_idle) && (state_r != st_idle) && copy_r;
		end
	end

	assign asleep = (state_r == st_sleep);
	assign idling = (state_r == st_idle);
	assign busy = (state_r == st_busy);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	property p_wake_code;
		(state_r == st_wake) && (state_nxt == st_ready) |=> (code_r == 8'h11) && (ptr_r == 3'h0);
	endproperty
	a_wake_code: assert property (p_wake_code) else $error("wake block code wrong");
	property p_crc_first;
		(state_r == st_rx) && take_byte && (idx_r != 8'h00) && (pos == cnt) && !crc_good
		|=> (code_r == 8'hff) && (state_r == st_ready) && !exec_valid;
	endproperty
	a_crc_first: assert property (p_crc_first) else $error("crc error not reported first");
	property p_short_parse;
		(state_r == st_rx) && take_byte && (idx_r != 8'h00) && (pos == cnt) && crc_good
		&& (cmd_r.count < 8'h07) |=> (code_r == 8'h03) ##1 !exec_valid;
	endproperty
	a_short_parse: assert property (p_short_parse) else $error("short block executed");
	property p_busy_deaf;
		ev_take && (state_r == st_busy) |=> !answer_r.valid;
	endproperty
	a_busy_deaf: assert property (p_busy_deaf) else $error("answer while busy");
	property p_rx_noread;
		take_read && (state_r == st_rx) |=> !answer_r.valid && (state_r != st_ready || ptr_r == 3'h0);
	endproperty
	a_rx_noread: assert property (p_rx_noread) else $error("read served mid block");
	property p_watchdog;
		is_awake && (wdog_r == WATCHDOG_CYC - 1) |=> asleep ##1 (wdog_r == 32'h0);
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("watchdog did not force sleep");
	property p_sleep_clear;
		$rose(asleep) |-> volatile_clear && (code_r == 8'h00) && !copy_r;
	endproperty
	a_sleep_clear: assert property (p_sleep_clear) else $error("sleep left state behind");
	property p_idle_digest;
		$rose(idling) && $past(copy_r) |-> digest_discard && !volatile_clear;
	endproperty
	a_idle_digest: assert property (p_idle_digest) else $error("copy digest kept on idle");
	property p_exec_block;
		busy && exec_done |=> (state_r == st_ready) && (code_r == $past(exec_result.code));
	endproperty
	a_exec_block: assert property (p_exec_block) else $error("result block missing");
	property p_count_first;
		take_read && (state_r == st_ready) && (ptr_r == 3'h0) |=> answer_r.valid
		&& (answer_r.data == 8'h04);
	endproperty
	a_count_first: assert property (p_count_first) else $error("block count byte wrong");
	property p_sleep_flag;
		(state_r == st_ready) && take_byte && fl_sleep && !fl_reset |=> asleep;
	endproperty
	a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag ignored");
	c_exec: cover property (exec_valid ##[1:1000] exec_done);
	c_crc_bad: cover property (busy == 1'b0 && code_r == 8'hff);
	c_idle_wake: cover property (idling ##[1:1000] (state_r == st_wake));

endmodule : auth_frame

// ===== logic/auth_frame_map.svh
`ifndef AUTH_FRAME_MAP_SVH
`define AUTH_FRAME_MAP_SVH

// ----------------------------------------
// Flags, status codes, block layout
// ----------------------------------------
`define FLAG_RESET_I2C 8'h00
`define FLAG_SLEEP_I2C 8'h01
`define FLAG_SLEEP_SW 8'hcc
`define FLAG_IDLE_I2C 8'h02
`define FLAG_IDLE_SW 8'hbb
`define FLAG_CMD_I2C 8'h03
`define FLAG_CMD_SW 8'h77
`define CODE_OK 8'h00
`define CODE_MISCOMPARE 8'h01
`define CODE_PARSE 8'h03
`define CODE_EXEC 8'h0f
`define CODE_WAKE 8'h11
`define CODE_COMM 8'hff
`define STATUS_COUNT 8'h04
`define CMD_MIN_COUNT 8'h07
`define CRC_MIN_COUNT 8'h04
`define CRC_POLY 16'h8005
`define CRC_INIT 16'h0000

// ----------------------------------------
// Timing, 20 ns clock
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define WAKE_LOW_US 60
`define WAKE_READY_US 2500
`define TIMEOUT_US 10000
`define WATCHDOG_US 1000000
`define WAKE_LOW_CYC ((`WAKE_LOW_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_READY_CYC ((`WAKE_READY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_CYC ((`TIMEOUT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WATCHDOG_CYC ((`WATCHDOG_US * 1000) / `CLK_PERIOD_NS)

`endif

// ===== logic/auth_frame_pkg.sv
package auth_frame_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [5:0] {
		st_sleep = 6'b000001,
		st_idle = 6'b000010,
		st_wake = 6'b000100,
		st_ready = 6'b001000,
		st_rx = 6'b010000,
		st_busy = 6'b100000
	} state_t;

	typedef enum logic [1:0] {
		ev_byte = 2'h0,
		ev_read = 2'h1,
		ev_start = 2'h2,
		ev_stop = 2'h3
	} event_kind_t;

	typedef struct packed {
		event_kind_t kind;
		logic [7:0] data;
	} link_event_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rd_answer_t;

	typedef struct packed {
		logic [7:0] count;
		logic [7:0] opcode;
		logic [7:0] first_parameter;
		logic [15:0] second_parameter;
	} cmd_t;

	typedef struct packed {
		logic [7:0] code;
		logic digest_copy;
	} exec_result_t;

endpackage : auth_frame_pkg

// ===== verification/host_link.sv
`timescale 1ns/1ns

module host_link (
	output logic link_clock,
	input wire logic link_event_ready,
	input wire logic link_rd_valid,
	input wire auth_frame_pkg::rd_answer_t link_rd_answer,
	output logic link_event_valid,
	output auth_frame_pkg::link_event_t link_event
);
	import auth_frame_pkg::*;
	logic run;

	// Link clock runs only inside transfers; free-running until the first one
	initial begin
		run = 1'b1;
		link_clock = 1'b0;
		link_event_valid = 1'b0;
		link_event = '0;
		#13;
		forever begin
			#40;
			if (run || link_clock) link_clock = ~link_clock;
		end
	end

	// One event per handshake; held until the edge that samples ready high
	task automatic xfer(input event_kind_t kind, input logic [7:0] data,
		output rd_answer_t ans);
		int n;
		ans = '0;
		run = 1'b1;
		// Sample just after each edge so the design's registers have settled
		do begin
			@(posedge link_clock);
			#1;
		end while (link_event_ready !== 1'b1);
		link_event_valid = 1'b1;
		link_event = '{kind, data};
		@(posedge link_clock);
		#1;
		link_event_valid = 1'b0;
		link_event = ~link_event; // Released lines show junk, not the old value
		if (kind == ev_read) begin
			n = 0;
			while (link_rd_valid !== 1'b1 && n < 16) begin
				@(posedge link_clock);
				#1;
				n++;
			end
			// A missing answer stays all zero, which no expected value matches
			if (link_rd_valid === 1'b1) ans = link_rd_answer;
		end
		run = 1'b0;
	endtask : xfer
endmodule : host_link

// ===== verification/auth_frame_tb.sv
`timescale 1ns/1ns

module auth_frame_tb;
	import auth_frame_pkg::*;
	localparam int WR = 20;
	localparam int TO = 50;
	localparam int WD = 4000;
	logic clock, reset, sda_in, i2c_mode, exec_done;
	logic link_clock, link_event_valid, link_event_ready, link_rd_valid;
	logic exec_valid, asleep, idling, busy, volatile_clear, digest_discard;
	link_event_t link_event;
	rd_answer_t link_rd_answer;
	cmd_t exec_cmd;
	exec_result_t exec_result;
	int n_errors = 0;
	int total_checks = 0;
	int n_ex = 0;
	int n_vc = 0;
	int n_dd = 0;

	auth_frame #(.WAKE_READY_CYC(WR), .TIMEOUT_CYC(TO), .WATCHDOG_CYC(WD)) DUT (
		.clock(clock), .reset(reset), .link_clock(link_clock), .sda_in(sda_in),
		.i2c_mode(i2c_mode), .link_event_valid(link_event_valid),
		.link_event_ready(link_event_ready), .link_event(link_event),
		.link_rd_valid(link_rd_valid), .link_rd_answer(link_rd_answer),
		.exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_done(exec_done),
		.exec_result(exec_result), .asleep(asleep), .idling(idling), .busy(busy),
		.volatile_clear(volatile_clear), .digest_discard(digest_discard));

	host_link host (.link_clock(link_clock), .link_event_ready(link_event_ready),
		.link_rd_valid(link_rd_valid), .link_rd_answer(link_rd_answer),
		.link_event_valid(link_event_valid), .link_event(link_event));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Pulses last one cycle, so count them as they pass
	always @(posedge clock) begin
		if (exec_valid === 1'b1) n_ex++;
		if (volatile_clear === 1'b1) n_vc++;
		if (digest_discard === 1'b1) n_dd++;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic complete_run();
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Zero start, each byte fed low bit first
	function automatic logic [15:0] crc16(input logic [7:0] b [8], input int n);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 0; i < n; i++) begin
			for (int k = 0; k < 8; k++) begin
				c = (b[i][k] ^ c[15]) ? ((c << 1) ^ 16'h8005) : (c << 1);
			end
		end
		return c;
	endfunction : crc16

	task automatic ev(input event_kind_t k, input logic [7:0] d);
		rd_answer_t a;
		host.xfer(k, d, a);
	endtask : ev

	task automatic rd_refused();
		rd_answer_t a;
		host.xfer(ev_read, 8'h00, a);
		chk(a, {1'b0, 8'hff});
	endtask : rd_refused

	task automatic rdblk(input logic [7:0] code);
		logic [7:0] b [8];
		logic [15:0] c;
		rd_answer_t a;
		b = '{8'h04, code, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		c = crc16(b, 2);
		b[2] = c[7:0];
		b[3] = c[15:8];
		ev(ev_byte, 8'h00);
		for (int i = 0; i < 4; i++) begin
			host.xfer(ev_read, 8'h00, a);
			chk(a, {1'b1, b[i]});
		end
	endtask : rdblk

	task automatic send(input logic [7:0] flag, input logic [7:0] cnt,
		input logic [7:0] op, input logic bad);
		logic [7:0] b [8];
		logic [15:0] c;
		b = '{cnt, op, 8'h5a, 8'h34, 8'h12, 8'h00, 8'h00, 8'h00};
		c = crc16(b, cnt - 2) ^ {15'h0, bad};
		ev(ev_byte, flag);
		for (int i = 0; i < cnt - 2; i++) ev(ev_byte, b[i]);
		ev(ev_byte, c[7:0]);
		ev(ev_byte, c[15:8]);
	endtask : send

	task automatic wake();
		@(posedge clock);
		#1;
		sda_in = 1'b0;
		repeat (3010) @(posedge clock);
		#1;
		sda_in = 1'b1;
		repeat (WR + 20) @(posedge clock);
		chk({asleep, idling}, 2'b00);
	endtask : wake

	task automatic cmd(input logic [7:0] flag, input logic [7:0] op,
		input logic [7:0] code, input logic dc);
		int n0;
		n0 = n_ex;
		send(flag, 8'h07, op, 1'b0);
		repeat (8) @(posedge clock);
		chk(n_ex - n0, 1);
		chk(exec_cmd, {8'h07, op, 8'h5a, 16'h1234});
		chk(busy, 1'b1);
		rd_refused();
		@(posedge clock);
		#1;
		exec_done = 1'b1;
		exec_result = '{code, dc};
		@(posedge clock);
		#1;
		exec_done = 1'b0;
		repeat (3) @(posedge clock);
		chk(busy, 1'b0);
		rdblk(code);
	endtask : cmd

	task automatic enter(input logic [7:0] flag, input logic idle);
		int v0, d0;
		v0 = n_vc;
		d0 = n_dd;
		ev(ev_byte, flag);
		ev(ev_stop, 8'h00);
		repeat (20) @(posedge clock);
		chk({asleep, idling}, {~idle, idle});
		chk(n_vc - v0, {31'h0, ~idle});
		chk(n_dd - d0, {31'h0, idle});
	endtask : enter

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_codes();
		logic [7:0] codes [4];
		codes = '{8'h00, 8'h01, 8'h03, 8'h0f};
		wake();
		rdblk(8'h11);
		rdblk(8'h11);
		for (int i = 0; i < 4; i++) cmd(8'h03, 8'h08 + i, codes[i], i == 3);
		enter(8'h02, 1'b1);
		wake();
		rdblk(8'h11);
	endtask : s_codes

	task automatic s_errors();
		int n0;
		n0 = n_ex;
		send(8'h03, 8'h07, 8'h08, 1'b1);
		repeat (8) @(posedge clock);
		chk(n_ex - n0, 0);
		rdblk(8'hff);
		send(8'h03, 8'h05, 8'h08, 1'b0);
		repeat (8) @(posedge clock);
		chk(n_ex - n0, 0);
		rdblk(8'h03);
		ev(ev_byte, 8'h03);
		ev(ev_byte, 8'h07);
		ev(ev_byte, 8'h08);
		rd_refused();
		ev(ev_stop, 8'h00);
		rdblk(8'hff);
		enter(8'h01, 1'b0);
		rd_refused();
	endtask : s_errors

	task automatic s_watchdog();
		int v0;
		wake();
		v0 = n_vc;
		ev(ev_byte, 8'h03);
		ev(ev_byte, 8'h07);
		repeat (WD - 400) @(posedge clock);
		chk(asleep, 1'b0);
		repeat (500) @(posedge clock);
		chk(asleep, 1'b1);
		chk(n_vc - v0, 1);
	endtask : s_watchdog

	task automatic s_single_wire();
		@(posedge clock);
		#1;
		i2c_mode = 1'b0;
		wake();
		ev(ev_byte, 8'h77);
		ev(ev_byte, 8'h07);
		repeat (TO - 20) @(posedge clock);
		chk(asleep, 1'b0);
		repeat (50) @(posedge clock);
		chk(asleep, 1'b1);
		wake();
		rdblk(8'h11);
		cmd(8'h77, 8'h1b, 8'h00, 1'b0);
		enter(8'hcc, 1'b0);
	endtask : s_single_wire

	initial begin
		#1000000;
		n_errors++;
		complete_run();
	end

	initial begin
		reset = 1'b1;
		sda_in = 1'b1;
		i2c_mode = 1'b1;
		exec_done = 1'b0;
		exec_result = '0;
		repeat (12) @(posedge clock);
		#1;
		reset = 1'b0;
		rd_refused();
		s_codes();
		s_errors();
		s_watchdog();
		s_single_wire();
		complete_run();
	end
endmodule : auth_frame_tb
